/* core/sep_io_burst2_sram_port.sv */
`timescale 1ns/1ps

module sep_io_burst2_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_WIDE,
  parameter int BYTES  = sram_port_pkg::BYTES_WIDE,
  parameter int SINGLE_DETECT_CYCLES = sram_port_pkg::SINGLE_DETECT_CYCLES
) (
  // clock and reset
  input  wire logic                                   core_clk_in,
  input  wire logic                                   reset_in,
  // clock pins
  input  wire logic                                   input_clock_in,
  input  wire logic                                   input_clock_n_in,
  input  wire logic                                   output_clock_in,
  input  wire logic                                   output_clock_n_in,
  // command and address pins
  input  wire logic                                   read_select_n_in,
  input  wire logic                                   write_select_n_in,
  input  wire logic [ADDR_W-1:0]                      sync_address_in,
  input  wire logic [BYTES-1:0]                       byte_write_n_in,
  // data pins
  input  wire logic [BYTES*sram_port_pkg::LANE_W-1:0] write_data_in,
  output logic      [BYTES*sram_port_pkg::LANE_W-1:0] read_data_out,
  output logic                                        read_data_oe_out,
  // echo clocks
  output logic                                        echo_clock_out,
  output logic                                        echo_clock_n_out
);

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = BYTES * sram_port_pkg::LANE_W;
  localparam int BUS_W  = 2 + ADDR_W + BYTES + DATA_W;
  localparam int SD_W   = $clog2(SINGLE_DETECT_CYCLES + 1);
  localparam int HALF_WAIT  = 40;
  localparam int CYCLE_WAIT = 80;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [sram_port_pkg::CLK_COUNT-1:0] clk_lvl;
  logic [sram_port_pkg::CLK_COUNT-1:0] clk_prev_reg;
  logic [BUS_W-1:0]                    bus_lvl;

  sram_port_pin_sync #(
    .WIDTH (sram_port_pkg::CLK_COUNT),
    .INIT  ('0)
  ) u_clk_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({output_clock_n_in, output_clock_in, input_clock_n_in, input_clock_in}),
    .level_out   (clk_lvl)
  );

  // selects start inactive so no command is seen at reset release
  sram_port_pin_sync #(
    .WIDTH (BUS_W),
    .INIT  ({2'h3, {(BUS_W-2){1'b0}}})
  ) u_bus_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({read_select_n_in, write_select_n_in, sync_address_in,
                   byte_write_n_in, write_data_in}),
    .level_out   (bus_lvl)
  );

  logic              rd_n_s;
  logic              wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [BYTES-1:0]  bw_n_s;
  logic [DATA_W-1:0] din_s;

  assign {rd_n_s, wr_n_s, addr_s, bw_n_s, din_s} = bus_lvl;

  // ----------------------------------------------------------------
  // edge detection and clocking mode
  // ----------------------------------------------------------------
  wire [sram_port_pkg::CLK_COUNT-1:0] clk_rise = clk_lvl & ~clk_prev_reg;
  wire k_rise  = clk_rise[sram_port_pkg::CLK_K];
  wire kn_rise = clk_rise[sram_port_pkg::CLK_KN];
  wire c_rise  = clk_rise[sram_port_pkg::CLK_C];
  wire cn_rise = clk_rise[sram_port_pkg::CLK_CN];
  wire oc_high = clk_lvl[sram_port_pkg::CLK_C] & clk_lvl[sram_port_pkg::CLK_CN];

  logic [SD_W-1:0] single_cnt_reg;
  logic [SD_W-1:0] single_cnt_next;
  logic            single_mode_reg;
  wire             single_reached = (single_cnt_reg == SD_W'(SINGLE_DETECT_CYCLES));

  // both output clocks high for longer than any half period means tied high
  assign single_cnt_next = !oc_high ? '0 :
                           single_reached ? single_cnt_reg : single_cnt_reg + SD_W'(1);

  // launch edges come from the output pair unless it is tied high
  wire launch_a = single_mode_reg ? kn_rise : cn_rise;
  wire launch_b = single_mode_reg ? k_rise  : c_rise;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      clk_prev_reg    <= '1;
      single_cnt_reg  <= '0;
      single_mode_reg <= 1'b0;
    end else begin
      clk_prev_reg    <= clk_lvl;
      single_cnt_reg  <= single_cnt_next;
      single_mode_reg <= single_reached;
    end
  end

  // ----------------------------------------------------------------
  // storage array and write buffers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

  sram_port_pkg::wr_phase_t wr_phase_reg;
  logic [DATA_W-1:0]        wd0_reg;
  logic [BYTES-1:0]         wm0_reg;
  logic                     buf_valid_reg;
  logic [ADDR_W-1:0]        buf_addr_reg;
  logic [DATA_W-1:0]        buf_d0_reg;
  logic [DATA_W-1:0]        buf_d1_reg;
  logic [BYTES-1:0]         buf_m0_reg;
  logic [BYTES-1:0]         buf_m1_reg;

  wire wr_cmd   = k_rise & ~wr_n_s;
  wire buf_load = kn_rise & (wr_phase_reg == sram_port_pkg::WR_ADDR);
  wire [BYTES-1:0] in_mask = ~bw_n_s;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wr_phase_reg <= sram_port_pkg::WR_IDLE;
      wd0_reg      <= '0;
      wm0_reg      <= '0;
    end else begin
      case (wr_phase_reg)
        sram_port_pkg::WR_IDLE: begin
          if (wr_cmd) begin
            wr_phase_reg <= sram_port_pkg::WR_ADDR;
            wd0_reg      <= din_s;
            wm0_reg      <= in_mask;
          end
        end
        sram_port_pkg::WR_ADDR: begin
          if (kn_rise) begin
            wr_phase_reg <= sram_port_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_phase_reg <= sram_port_pkg::WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      buf_valid_reg <= 1'b0;
      buf_addr_reg  <= '0;
      buf_d0_reg    <= '0;
      buf_d1_reg    <= '0;
      buf_m0_reg    <= '0;
      buf_m1_reg    <= '0;
    end else if (buf_load) begin
      buf_valid_reg <= 1'b1;
      buf_addr_reg  <= addr_s;
      buf_d0_reg    <= wd0_reg;
      buf_m0_reg    <= wm0_reg;
      buf_d1_reg    <= din_s;
      buf_m1_reg    <= in_mask;
    end
  end

  // previous burst reaches the array only when the next write arrives
  always_ff @(posedge core_clk_in) begin
    if (buf_load && buf_valid_reg) begin
      for (int l = 0; l < BYTES; l++) begin
        if (buf_m0_reg[l]) begin
          mem[{buf_addr_reg, sram_port_pkg::BURST_FIRST}][l*sram_port_pkg::LANE_W +:
            sram_port_pkg::LANE_W] <= buf_d0_reg[l*sram_port_pkg::LANE_W +:
            sram_port_pkg::LANE_W];
        end
        if (buf_m1_reg[l]) begin
          mem[{buf_addr_reg, sram_port_pkg::BURST_SECOND}][l*sram_port_pkg::LANE_W +:
            sram_port_pkg::LANE_W] <= buf_d1_reg[l*sram_port_pkg::LANE_W +:
            sram_port_pkg::LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // coherent read view
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge_word(
    input logic [DATA_W-1:0] base,
    input logic [DATA_W-1:0] bd,
    input logic [BYTES-1:0]  bm,
    input logic              bhit,
    input logic [DATA_W-1:0] nd,
    input logic [BYTES-1:0]  nm,
    input logic              nhit
  );
    logic [DATA_W-1:0] w;
    w = base;
    for (int l = 0; l < BYTES; l++) begin
      if (bhit && bm[l]) begin
        w[l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
          bd[l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
      end
      if (nhit && nm[l]) begin
        w[l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
          nd[l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
      end
    end
    return w;
  endfunction

  logic              rd0_v_reg;
  logic [ADDR_W-1:0] rd0_a_reg;
  logic              rd1_v_reg;
  logic [ADDR_W-1:0] rd1_a_reg;

  wire buf_hit = buf_valid_reg && (buf_addr_reg == rd1_a_reg);
  wire new_hit = buf_load && (addr_s == rd1_a_reg);

  wire [DATA_W-1:0] arr0 = mem[{rd1_a_reg, sram_port_pkg::BURST_FIRST}];
  wire [DATA_W-1:0] arr1 = mem[{rd1_a_reg, sram_port_pkg::BURST_SECOND}];
  wire [DATA_W-1:0] word0 = merge_word(arr0, buf_d0_reg, buf_m0_reg, buf_hit,
                                       wd0_reg, wm0_reg, new_hit);
  wire [DATA_W-1:0] word1 = merge_word(arr1, buf_d1_reg, buf_m1_reg, buf_hit,
                                       din_s, in_mask, new_hit);

  // ----------------------------------------------------------------
  // read pipeline and output launch
  // ----------------------------------------------------------------
  sram_port_pkg::rd_phase_t rd_phase_reg;
  logic [DATA_W-1:0]        word2_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd0_v_reg <= 1'b0;
      rd0_a_reg <= '0;
      rd1_v_reg <= 1'b0;
      rd1_a_reg <= '0;
    end else if (k_rise) begin
      rd0_v_reg <= ~rd_n_s;
      rd0_a_reg <= addr_s;
      rd1_v_reg <= rd0_v_reg;
      rd1_a_reg <= rd0_a_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_phase_reg     <= sram_port_pkg::RD_IDLE;
      word2_reg        <= '0;
      read_data_out    <= '0;
      read_data_oe_out <= sram_port_pkg::OE_RESET;
      echo_clock_out   <= sram_port_pkg::ECHO_RESET;
      echo_clock_n_out <= ~sram_port_pkg::ECHO_RESET;
    end else begin
      if (launch_a) begin
        echo_clock_out   <= 1'b0;
        echo_clock_n_out <= 1'b1;
        read_data_oe_out <= rd1_v_reg;
        if (rd1_v_reg) begin
          rd_phase_reg  <= sram_port_pkg::RD_FIRST;
          read_data_out <= word0;
          word2_reg     <= word1;
        end else begin
          rd_phase_reg <= sram_port_pkg::RD_IDLE;
        end
      end else if (launch_b) begin
        echo_clock_out   <= 1'b1;
        echo_clock_n_out <= 1'b0;
        case (rd_phase_reg)
          sram_port_pkg::RD_FIRST: begin
            rd_phase_reg  <= sram_port_pkg::RD_SECOND;
            read_data_out <= word2_reg;
          end
          sram_port_pkg::RD_SECOND,
          sram_port_pkg::RD_IDLE: begin
            rd_phase_reg <= rd_phase_reg;
          end
          default: begin
            rd_phase_reg <= sram_port_pkg::RD_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_burst_of_two: assert property (
    $rose(rd_phase_reg == sram_port_pkg::RD_FIRST) |->
      ##[1:HALF_WAIT] (rd_phase_reg == sram_port_pkg::RD_SECOND))
    else $error("first word not followed by second word");

  a_read_start: assert property (
    (k_rise && !rd_n_s) |=> rd0_v_reg ##0 (rd0_a_reg == $past(addr_s)))
    else $error("read command not registered");

  a_launch_edge: assert property (
    $changed(read_data_out) |-> $past(launch_a || launch_b))
    else $error("read data changed off a launch edge");

  a_echo_pair: assert property (
    (echo_clock_out != echo_clock_n_out) and
    ($changed(read_data_out) |-> $changed(echo_clock_out)))
    else $error("echo clocks not complementary or not aligned");

  a_single_first: assert property (
    (single_mode_reg && kn_rise && rd1_v_reg) |=>
      read_data_oe_out && (read_data_out == $past(word0)))
    else $error("single clock first word not launched");

  a_second_word: assert property (
    (launch_b && !launch_a && rd_phase_reg == sram_port_pkg::RD_FIRST) |=>
      (read_data_out == $past(word2_reg)) && echo_clock_out)
    else $error("second word wrong or late");

  a_nop_keeps: assert property (
    (rd_phase_reg == sram_port_pkg::RD_FIRST && !launch_a) |=>
      (rd_phase_reg != sram_port_pkg::RD_IDLE))
    else $error("burst cut short");

  a_write_take: assert property (
    (wr_cmd && wr_phase_reg == sram_port_pkg::WR_IDLE) |=>
      (wr_phase_reg == sram_port_pkg::WR_ADDR) && (wd0_reg == $past(din_s)))
    else $error("write command or first word not taken");

  a_addr_capture: assert property (
    buf_load |=> buf_valid_reg && (buf_addr_reg == $past(addr_s)) &&
      (buf_d1_reg == $past(din_s)))
    else $error("write address or second word not captured");

  a_buffer_hold: assert property (
    (buf_valid_reg && !buf_load) |=> $stable(buf_addr_reg) && $stable(buf_d0_reg))
    else $error("write buffer changed without a write");

  a_no_write: assert property (
    (wr_phase_reg == sram_port_pkg::WR_IDLE && !(k_rise && !wr_n_s)) |=>
      (wr_phase_reg == sram_port_pkg::WR_IDLE))
    else $error("write started with write select high");

  a_wr_bound: assert property (
    (wr_phase_reg == sram_port_pkg::WR_ADDR) |-> ##[0:CYCLE_WAIT]
      (wr_phase_reg == sram_port_pkg::WR_IDLE))
    else $error("write address phase never closed");

  c_single_read: cover property (
    single_mode_reg && launch_a && rd1_v_reg);
  c_dual_read: cover property (
    !single_mode_reg && launch_a && rd1_v_reg);
  c_back_to_back: cover property (
    buf_load ##[1:CYCLE_WAIT] buf_load);
  c_bypass_hit: cover property (
    launch_a && rd1_v_reg && (buf_hit || new_hit));

endmodule // sep_io_burst2_sram_port

/* core/sram_port_pin_sync.sv */
`timescale 1ns/1ps

module sram_port_pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  // pins
  input  wire logic [WIDTH-1:0] async_in,
  // filtered level
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_next;
  wire  [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

  // a bit changes only once stages two and three agree
  assign level_next = (s2_reg & agree) | (level_out & ~agree);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s1_reg    <= INIT;
      s2_reg    <= INIT;
      s3_reg    <= INIT;
      level_out <= INIT;
    end else begin
      s1_reg    <= async_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= level_next;
    end
  end

endmodule // sram_port_pin_sync

/* core/sram_port_pkg.sv */
package sram_port_pkg;

  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int LANE_W       = 9;
  localparam int BYTES_WIDE   = 4;
  localparam int BYTES_NARROW = 2;
  localparam int ADDR_W_WIDE  = 19;
  localparam int ADDR_W_NARROW = 20;

  // ----------------------------------------------------------------
  // clock bundle bit positions
  // ----------------------------------------------------------------
  localparam int CLK_K     = 0;
  localparam int CLK_KN    = 1;
  localparam int CLK_C     = 2;
  localparam int CLK_CN    = 3;
  localparam int CLK_COUNT = 4;

  // ----------------------------------------------------------------
  // burst word index, one-bit linear
  // ----------------------------------------------------------------
  localparam logic BURST_FIRST  = 1'h0;
  localparam logic BURST_SECOND = 1'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ        = 200;
  localparam int SINGLE_DETECT_NS    = 320;
  localparam int SINGLE_DETECT_CYCLES =
    (SINGLE_DETECT_NS * CORE_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic ECHO_RESET = 1'h0;
  localparam logic OE_RESET   = 1'h0;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RD_IDLE   = 3'h1,
    RD_FIRST  = 3'h2,
    RD_SECOND = 3'h4
  } rd_phase_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_ADDR = 2'h2
  } wr_phase_t;

endpackage

/* verif/sep_io_burst2_sram_port_tb_top.sv */
`timescale 1ns/1ps

module sep_io_burst2_sram_port_tb_top;
  localparam int AW = 8;
  localparam int LW = sram_port_pkg::LANE_W;
  localparam int BW = sram_port_pkg::BYTES_WIDE;
  localparam int DW = BW * LW;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic          core_clk, reset, single_mode;
  logic          k, kn, c, cn, rd_n, wr_n, oe, echo, echo_n;
  logic [AW-1:0] addr;
  logic [BW-1:0] bw_n;
  logic [DW-1:0] wdata, rdata;
  logic [DW-1:0] shadow [2**(AW+1)];
  logic [DW-1:0] exp_q[$];
  int            mismatches = 0;
  int            cmp_count = 0;
  int            lat_lo;

  sep_io_burst2_sram_port #(.ADDR_W(AW), .BYTES(BW), .SINGLE_DETECT_CYCLES(40)) dut_u (
    .core_clk_in(core_clk), .reset_in(reset), .input_clock_in(k), .input_clock_n_in(kn),
    .output_clock_in(c), .output_clock_n_in(cn), .read_select_n_in(rd_n),
    .write_select_n_in(wr_n), .sync_address_in(addr), .byte_write_n_in(bw_n),
    .write_data_in(wdata), .read_data_out(rdata), .read_data_oe_out(oe),
    .echo_clock_out(echo), .echo_clock_n_out(echo_n));

  sram_host_model #(.AW(AW), .DW(DW), .BW(BW)) host_u (
    .core_clk_in(core_clk), .single_mode_in(single_mode), .input_clock_out(k),
    .input_clock_n_out(kn), .output_clock_out(c), .output_clock_n_out(cn),
    .read_select_n_out(rd_n), .write_select_n_out(wr_n), .sync_address_out(addr),
    .byte_write_n_out(bw_n), .write_data_out(wdata), .read_data_in(rdata),
    .read_data_oe_in(oe), .echo_clock_in(echo));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                          input logic [BW-1:0] m);
    merge = o;
    for (int l = 0; l < BW; l++) begin
      if (m[l] == 1'h0) merge[l*LW +: LW] = n[l*LW +: LW];
    end
  endfunction

  // one K cycle of commands, expectation taken before the write lands
  task automatic rw(input logic r, input logic [AW-1:0] ra, input logic w,
                    input logic [AW-1:0] wa, input logic [DW-1:0] d1,
                    input logic [DW-1:0] d2, input logic [BW-1:0] m1, input logic [BW-1:0] m2);
    host_u.cmd_q.push_back({r, ra, w, wa, d1, d2, m1, m2});
    if (r) begin
      exp_q.push_back(shadow[{ra, 1'h0}]);
      exp_q.push_back(shadow[{ra, 1'h1}]);
    end
    if (w) begin
      shadow[{wa, 1'h0}] = merge(shadow[{wa, 1'h0}], d1, m1);
      shadow[{wa, 1'h1}] = merge(shadow[{wa, 1'h1}], d2, m2);
    end
  endtask

  task automatic drain(input int n);
    int t;
    // room for a queue of up to ten commands ahead of the last read
    repeat (320 + 64 * n) begin
      if (host_u.rdata_q.size() < 2 * n) @(posedge core_clk);
    end
    check_count(host_u.rdata_q.size(), 2 * n, 2 * n);
    for (int i = 0; i < n && host_u.rdata_q.size() >= 2; i++) begin
      t = host_u.rt_q.pop_front();
      check_count(host_u.ct_q[0] - t, lat_lo + 2, lat_lo + 8);
      check_count(host_u.ct_q[1] - host_u.ct_q[0], 16, 16);
      void'(host_u.ct_q.pop_front());
      void'(host_u.ct_q.pop_front());
      check_data(host_u.rdata_q.pop_front(), exp_q.pop_front());
      check_data(host_u.rdata_q.pop_front(), exp_q.pop_front());
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    check_data(rdata, '0);
    check_data(DW'({oe, echo, echo_n}), DW'({sram_port_pkg::OE_RESET,
               sram_port_pkg::ECHO_RESET, ~sram_port_pkg::ECHO_RESET}));
  endtask

  task automatic s_basic(input logic [7:0] s, input logic [AW-1:0] b);
    rw(0, '0, 1, b, {4{s, 1'h1}}, {4{~s, 1'h0}}, 4'h0, 4'h0);
    rw(0, '0, 1, AW'(b + 1), {4{s ^ 8'h5A, 1'h0}}, {4{s, 1'h0}}, 4'h0, 4'h0);
    rw(1, b, 0, '0, '0, '0, '0, '0);
    rw(0, '0, 0, '0, '0, '0, '0, '0);
    rw(1, AW'(b + 1), 0, '0, '0, '0, '0, '0);
    rw(1, AW'(b + 1), 0, '0, '0, '0, '0, '0);
    drain(3);
  endtask

  task automatic s_lanes(input logic [AW-1:0] b);
    rw(0, '0, 1, b, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    rw(0, '0, 1, b, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'hA, 4'h5);
    rw(0, '0, 0, '0, '0, '0, '0, '0);
    rw(0, '0, 1, b, 36'hF_0F0F_0F0F, 36'h0_F0F0_F0F0, 4'hF, 4'hF);
    rw(1, b, 0, '0, '0, '0, '0, '0);
    drain(1);
  endtask

  task automatic s_coherent(input logic [AW-1:0] b);
    rw(0, '0, 1, AW'(b + 1), 36'h3_3333_CCCC, 36'hC_CCCC_3333, 4'h0, 4'h0);
    host_u.cmd_q.push_back({1'h1, b, 1'h0, AW'(0), DW'(0), DW'(0), BW'(0), BW'(0)});
    host_u.cmd_q.push_back({1'h1, AW'(b + 1), 1'h1, b, 36'h7_1234_5678, 36'h8_8765_4321,
                            BW'(0), BW'(0)});
    exp_q.push_back(36'h7_1234_5678);
    exp_q.push_back(36'h8_8765_4321);
    exp_q.push_back(36'h3_3333_CCCC);
    exp_q.push_back(36'hC_CCCC_3333);
    shadow[{b, 1'h0}] = 36'h7_1234_5678;
    shadow[{b, 1'h1}] = 36'h8_8765_4321;
    drain(2);
  endtask

  task automatic s_echo();
    int toggles = 0;
    int bad = 0;
    logic last;
    last = echo;
    repeat (320) begin
      @(posedge core_clk);
      #1;
      if (echo !== last) toggles++;
      if (echo_n !== ~echo) bad++;
      last = echo;
    end
    check_count(toggles, 20, 20);
    check_count(bad, 0, 0);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'h1;
    single_mode = 1'h0;
    lat_lo = 56;
    repeat (12) @(posedge core_clk);
    #1;
    s_reset();
    reset = 1'h0;
    repeat (200) @(posedge core_clk);
    #1;
    s_basic(8'h3C, 8'h10);
    s_lanes(8'h20);
    s_coherent(8'h30);
    s_echo();
    single_mode = 1'h1;
    reset = 1'h1;
    lat_lo = 48;
    repeat (12) @(posedge core_clk);
    #1;
    s_reset();
    reset = 1'h0;
    repeat (200) @(posedge core_clk);
    #1;
    s_basic(8'hC3, 8'h40);
    s_coherent(8'h50);
    test_done();
  end

  initial begin
    #(40000 * 5);
    mismatches++;
    test_done();
  end
endmodule // sep_io_burst2_sram_port_tb_top

/* verif/sram_host_model.sv */
`timescale 1ns/1ps

module sram_host_model #(
  parameter int AW = 8,
  parameter int DW = 36,
  parameter int BW = 4
) (
  // clock and mode
  input  wire logic          core_clk_in,
  input  wire logic          single_mode_in,
  // pins toward the memory
  output logic               input_clock_out,
  output logic               input_clock_n_out,
  output logic               output_clock_out,
  output logic               output_clock_n_out,
  output logic               read_select_n_out,
  output logic               write_select_n_out,
  output logic [AW-1:0]      sync_address_out,
  output logic [BW-1:0]      byte_write_n_out,
  output logic [DW-1:0]      write_data_out,
  // return path
  input  wire logic [DW-1:0] read_data_in,
  input  wire logic          read_data_oe_in,
  input  wire logic          echo_clock_in
);
  // ----------------------------------------------------------------
  // quarter-period sequencer, one K period is 32 core cycles
  // ----------------------------------------------------------------
  logic [2*AW+2*DW+2*BW+1:0] cmd_q[$];
  logic [DW-1:0]             rdata_q[$];
  int                        rt_q[$];
  int                        ct_q[$];
  int                        cyc = 0;
  logic                      echo_prev = 1'h0;
  logic                      r = 1'h0;
  logic                      w = 1'h0;
  logic [AW-1:0]             ra, wa;
  logic [DW-1:0]             d1, d2;
  logic [BW-1:0]             m1, m2;

  initial begin
    {input_clock_out, input_clock_n_out, output_clock_out, output_clock_n_out} = 4'h7;
    {read_select_n_out, write_select_n_out} = 2'h3;
    sync_address_out = '0;
    byte_write_n_out = '1;
    write_data_out = '0;
  end

  always @(posedge core_clk_in) begin
    #1;
    cyc++;
    // capture read words on echo edges
    if (echo_clock_in !== echo_prev && read_data_oe_in === 1'h1) begin
      rdata_q.push_back(read_data_in);
      ct_q.push_back(cyc);
    end
    echo_prev = echo_clock_in;
    case (cyc % 32)
      0: begin
        {input_clock_out, input_clock_n_out} = 2'h2;
        if (r) rt_q.push_back(cyc);
      end
      8: begin
        {output_clock_out, output_clock_n_out} = {1'h1, single_mode_in};
        sync_address_out = w ? wa : ~sync_address_out;
        write_data_out = w ? d2 : ~write_data_out;
        byte_write_n_out = w ? m2 : ~byte_write_n_out;
      end
      16: {input_clock_out, input_clock_n_out} = 2'h1;
      24: begin
        {r, ra, w, wa, d1, d2, m1, m2} = (cmd_q.size() > 0) ? cmd_q.pop_front() : '0;
        {output_clock_out, output_clock_n_out} = {single_mode_in, 1'h1};
        read_select_n_out = ~r;
        write_select_n_out = ~w;
        sync_address_out = r ? ra : ~sync_address_out;
        write_data_out = w ? d1 : ~write_data_out;
        byte_write_n_out = w ? m1 : ~byte_write_n_out;
      end
      default: ;
    endcase
  end
endmodule // sram_host_model
